/* File: adc_interrupt_enable_set_clear_bench.sv */
`timescale 1ns/100ps
module adc_interrupt_enable_set_clear_bench;
    import adc_irq_pkg::*;
    // ----------------------------------------
    // Stimulus rows: write, then expected enables
    // ----------------------------------------
    typedef struct packed {
        logic to_set;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] strb;
        logic [EVENT_COUNT-1:0] exp;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [OFS_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [STRB_W-1:0] pstrb = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    adc_event_t events = '0;
    logic [EVENT_COUNT-1:0] event_enable;
    logic irq;
    logic [DATA_W-1:0] rdat;
    logic err;
    logic [EVENT_COUNT-1:0] one;
    logic [OFS_W-1:0] wa;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    row_t rows [8] = '{
        '{1'b1, 32'h003FFFFF, 4'hF, 22'h3FFFFF},
        '{1'b0, 32'h00000001, 4'hF, 22'h3FFFFE},
        '{1'b0, 32'h00000000, 4'hF, 22'h3FFFFE},
        '{1'b1, 32'h00000000, 4'hF, 22'h3FFFFE},
        '{1'b0, 32'h002AAAAA, 4'hF, 22'h155554},
        '{1'b0, 32'h003FFFFF, 4'h1, 22'h155500},
        '{1'b1, 32'hFFC00000, 4'hF, 22'h155500},
        '{1'b0, 32'hFFFFFFFF, 4'hF, 22'h000000}};

    adc_irq_enable #(.ADDR_W(OFS_W)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
        .event_enable(event_enable), .irq(irq));

    always #5 pclk = ~pclk;

    // Hang guard: the full sequence needs well under 1000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Bus, compare and report tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [OFS_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [STRB_W-1:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_w(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t word got %h expected %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk_b

    // Both addresses read the same enable flops
    task automatic chk_both(input logic [EVENT_COUNT-1:0] exp);
        apb(1'b0, OFS_ENABLE_SET, '0, '0);
        chk_w(rdat, {10'h000, exp});
        apb(1'b0, OFS_DISABLE, '0, '0);
        chk_w(rdat, {10'h000, exp});
        chk_w({10'h000, event_enable}, {10'h000, exp});
    endtask : chk_both

    task automatic pulse(input int i);
        @(posedge pclk);
        events <= adc_event_t'(EVENT_COUNT'(1) << i);
        @(posedge pclk);
        events <= '0;
        #1;
    endtask : pulse

    task automatic tally_and_finish();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk_both('0);
        foreach (rows[k]) begin
            wa = rows[k].to_set ? OFS_ENABLE_SET : OFS_DISABLE;
            apb(1'b1, wa, rows[k].wdata, rows[k].strb);
            chk_b(err, 1'b0);
            chk_both(rows[k].exp);
        end
        // Unmapped place refuses and leaves enables alone
        apb(1'b1, 12'h300, 32'hFFFFFFFF, 4'hF);
        chk_b(err, 1'b1);
        apb(1'b0, 12'h300, '0, 4'h0);
        chk_b(err, 1'b1);
        chk_w(rdat, 32'h00000000);
        chk_both('0);
        // Status writes are taken but move no enable
        apb(1'b1, OFS_EVENT_STATUS, 32'hFFFFFFFF, 4'hF);
        chk_b(err, 1'b0);
        chk_both('0);
        // Each event bit against its own enable bit
        for (int i = 0; i < EVENT_COUNT; i++) begin
            one = EVENT_COUNT'(1) << i;
            apb(1'b1, OFS_ENABLE_SET, {10'h000, one}, 4'hF);
            pulse(i);
            chk_b(irq, 1'b1);
            apb(1'b0, OFS_EVENT_STATUS, '0, 4'h0);
            chk_w(rdat, {10'h000, one});
            @(posedge pclk);
            #1;
            chk_b(irq, 1'b0);
            apb(1'b1, OFS_DISABLE, {10'h000, one}, 4'hF);
            pulse(i);
            chk_b(irq, 1'b0);
            apb(1'b0, OFS_EVENT_STATUS, '0, 4'h0);
            chk_w(rdat, {10'h000, one});
        end
        // An event at the clearing edge of a status read must survive it
        one = EVENT_COUNT'(1);
        apb(1'b1, OFS_ENABLE_SET, {10'h000, one}, 4'hF);
        pulse(0);
        fork
            apb(1'b0, OFS_EVENT_STATUS, '0, 4'h0);
            begin
                repeat (2) @(posedge pclk);
                events <= adc_event_t'(one);
                @(posedge pclk);
                events <= '0;
            end
        join
        chk_w(rdat, {10'h000, one});
        #1;
        chk_b(irq, 1'b1);
        apb(1'b0, OFS_EVENT_STATUS, '0, 4'h0);
        chk_w(rdat, {10'h000, one});
        @(posedge pclk);
        #1;
        chk_b(irq, 1'b0);
        // Reset in mid-run drops every enable, flag and request
        apb(1'b1, OFS_ENABLE_SET, 32'h003FFFFF, 4'hF);
        pulse(0);
        chk_b(irq, 1'b1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk_w({10'h000, event_enable}, 32'h00000000);
        chk_b(irq, 1'b0);
        chk_b(pready, 1'b0);
        chk_both('0);
        apb(1'b0, OFS_EVENT_STATUS, '0, 4'h0);
        chk_w(rdat, 32'h00000000);
        tally_and_finish();
    end
endmodule : adc_interrupt_enable_set_clear_bench

/* File: adc_irq_enable.sv */
`timescale 1ns/100ps

// How it works
// - Disable register ones clear matching enables
// - Set register ones turn enables on
// - Either register reads back current enables
// - Bits zero to five: converter events
// - Next sixteen: channel high then low
// - Enables reset to all zero
module adc_irq_enable
    import adc_irq_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [STRB_W-1:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter events, one-cycle pulses on pclk
    input wire adc_event_t events,
    // Enable state and interrupt
    output logic [EVENT_COUNT-1:0] event_enable,
    output logic irq
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (ADDR_W < OFS_W || ADDR_W > DATA_W) begin : g_bad_addr_w
        $error("ADDR_W must lie between 12 and 32");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [OFS_W-1:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction : addr_hit

    function automatic logic [DATA_W-1:0] lane_mask(input logic [STRB_W-1:0] s);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < STRB_W; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction : lane_mask

    function automatic logic [DATA_W-1:0] widen(input logic [EVENT_COUNT-1:0] v);
        return {{(DATA_W - EVENT_COUNT){1'b0}}, v};
    endfunction : widen

    // ----------------------------------------
    // Bus phase tracking
    // ----------------------------------------
    bus_state_t bus_state_q;
    bus_state_t bus_state_d;
    logic setup_phase;
    logic access_done;
    logic hit_set;
    logic hit_clr;
    logic hit_status;
    logic hit_any;

    assign setup_phase = psel & ~penable;
    assign hit_set = addr_hit(paddr, OFS_ENABLE_SET);
    assign hit_clr = addr_hit(paddr, OFS_DISABLE);
    assign hit_status = addr_hit(paddr, OFS_EVENT_STATUS);
    assign hit_any = hit_set | hit_clr | hit_status;

    // A setup while the answer stands is not taken; the master releases first
    // One wait-free access phase: pready rises on the cycle after setup
    always_comb begin
        bus_state_d = bus_state_q;
        unique case (bus_state_q)
            BUS_WAIT: begin
                if (setup_phase) begin
                    bus_state_d = BUS_REPLY;
                end
            end
            BUS_REPLY: begin
                bus_state_d = BUS_WAIT;
            end
            default: begin
                bus_state_d = BUS_WAIT;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state_q <= BUS_WAIT;
        end else begin
            bus_state_q <= bus_state_d;
        end
    end

    assign pready = bus_state_q == BUS_REPLY;
    assign access_done = psel & penable & pready;

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    logic [DATA_W-1:0] strb_mask;
    logic [DATA_W-1:0] wbits;
    logic [EVENT_COUNT-1:0] wmask;
    logic wr_set_fire;
    logic wr_clr_fire;
    logic rd_status_fire;

    assign strb_mask = lane_mask(pstrb);
    assign wbits = pwdata & strb_mask;
    assign wmask = wbits[EVENT_COUNT-1:0];
    assign wr_set_fire = access_done & pwrite & hit_set;
    assign wr_clr_fire = access_done & pwrite & hit_clr;
    assign rd_status_fire = access_done & ~pwrite & hit_status;

    // ----------------------------------------
    // Enable flops and event status
    // ----------------------------------------
    logic [EVENT_COUNT-1:0] enable_q;
    logic [EVENT_COUNT-1:0] enable_d;
    logic [EVENT_COUNT-1:0] status_q;
    logic [EVENT_COUNT-1:0] status_d;
    logic [EVENT_COUNT-1:0] clr_snap_q;
    logic [EVENT_COUNT-1:0] clr_snap_d;
    logic [EVENT_COUNT-1:0] event_bits;
    logic irq_q;
    logic irq_d;

    // Struct packing puts the converter events low, then each channel pair
    assign event_bits = events;

    // Both registers drive one flop per event; zeros in the data leave it alone
    always_comb begin
        enable_d = enable_q;
        if (wr_set_fire) begin
            enable_d = enable_d | wmask;
        end
        if (wr_clr_fire) begin
            enable_d = enable_d & ~wmask;
        end
    end

    // Only bits that were read are cleared, so a new event is never lost
    // Flags are never masked; the enables only gate the interrupt
    always_comb begin
        status_d = status_q;
        if (rd_status_fire) begin
            status_d = status_d & ~clr_snap_q;
        end
        status_d = status_d | event_bits;
        irq_d = |(status_d & enable_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= ENABLE_RESET;
            status_q <= STATUS_RESET;
            irq_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    assign event_enable = enable_q;
    assign irq = irq_q;

    // ----------------------------------------
    // Read data and error answer
    // ----------------------------------------
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;

    // Captured in setup so the data output comes straight from flops
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        clr_snap_d = clr_snap_q;
        if (setup_phase && bus_state_q == BUS_WAIT) begin
            prdata_d = RDATA_RESET;
            pslverr_d = ~hit_any;
            clr_snap_d = '0;
            if (!pwrite) begin
                if (hit_set || hit_clr) begin
                    prdata_d = widen(enable_q);
                end else if (hit_status) begin
                    prdata_d = widen(status_q);
                    clr_snap_d = status_q;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RDATA_RESET;
            pslverr_q <= 1'b0;
            clr_snap_q <= STATUS_RESET;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            clr_snap_q <= clr_snap_d;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q & pready;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_disable_clears: assert property (
        wr_clr_fire |=> ((enable_q & $past(wmask)) == '0)
    ) else $error("disable write left an enable set");

    a_set_enables: assert property (
        (wr_set_fire && !wr_clr_fire) |=>
            ((enable_q & $past(wmask)) == $past(wmask))
    ) else $error("set write failed to enable");

    a_read_enable_state: assert property (
        (setup_phase && !pwrite && (hit_set || hit_clr) && bus_state_q == BUS_WAIT)
            |=> (prdata == widen($past(enable_q))) && pready
    ) else $error("enable readback wrong");

    a_started_bit_zero: assert property (
        events.started_event && !rd_status_fire |=> status_q[CONV_FIELD_LSB]
    ) else $error("started event not on bit zero");

    a_stopped_bit_five: assert property (
        events.stopped_event |=> status_q[CONV_FIELD_LSB + 5]
    ) else $error("stopped event not on bit five");

    a_chan7_low_bit: assert property (
        events.chan[CHAN_COUNT-1].below_lower |=> status_q[EVENT_COUNT-1]
    ) else $error("channel seven low limit misplaced");

    a_chan0_high_bit: assert property (
        events.chan[0].above_upper |=> status_q[LIMIT_FIELD_LSB]
    ) else $error("channel zero high limit misplaced");

    a_reset_zero: assert property (
        $rose(presetn) |-> (enable_q == '0) && (status_q == '0) && !irq
    ) else $error("enables not zero after reset");

    a_zeros_keep: assert property (
        (wr_set_fire || wr_clr_fire) |=>
            ((enable_q & ~$past(wmask)) == ($past(enable_q) & ~$past(wmask)))
    ) else $error("written zero changed an enable");

    a_irq_follows: assert property (
        irq == |(status_q & enable_q)
    ) else $error("interrupt disagrees with flags and enables");

    a_one_cycle_answer: assert property (
        (setup_phase && bus_state_q == BUS_WAIT) |=> pready ##1 !pready
    ) else $error("answer not one cycle after setup");

    a_ready_after_setup: assert property (
        pready |-> $past(setup_phase)
    ) else $error("answer without a setup cycle");

    a_unmapped_refused: assert property (
        (setup_phase && bus_state_q == BUS_WAIT && !hit_any) |=>
            pslverr && (prdata == RDATA_RESET)
    ) else $error("unmapped access not refused");

    a_mapped_accepted: assert property (
        (setup_phase && bus_state_q == BUS_WAIT && hit_any) |=> pready && !pslverr
    ) else $error("mapped access answered with an error");

    // Only the two enable addresses may move the flops
    a_other_write_inert: assert property (
        (access_done && pwrite && !hit_set && !hit_clr) |=> (enable_q == $past(enable_q))
    ) else $error("write elsewhere changed an enable");

    a_enable_stable: assert property (
        !(wr_set_fire || wr_clr_fire) |=> $stable(enable_q)
    ) else $error("enable moved without a write");

    a_upper_bits_zero: assert property (
        prdata[DATA_W-1:EVENT_COUNT] == '0
    ) else $error("unused read bits not zero");

    a_quiet_when_off: assert property (
        ((enable_q == '0) && !wr_set_fire) |=> !irq
    ) else $error("interrupt raised with every enable off");

    a_irq_on_event: assert property (
        (events.started_event && enable_q[CONV_FIELD_LSB] && !wr_clr_fire) |=> irq
    ) else $error("enabled event raised no interrupt");

    a_chan3_high_bit: assert property (
        events.chan[3].above_upper |=> status_q[LIMIT_FIELD_LSB + 6]
    ) else $error("channel three high limit misplaced");

    a_chan5_low_bit: assert property (
        events.chan[5].below_lower |=> status_q[LIMIT_FIELD_LSB + 11]
    ) else $error("channel five low limit misplaced");

    a_status_readback: assert property (
        (setup_phase && !pwrite && hit_status && bus_state_q == BUS_WAIT)
            |=> (prdata == widen($past(status_q)))
    ) else $error("status readback wrong");

    a_prdata_holds: assert property (
        !(setup_phase && bus_state_q == BUS_WAIT) |=> $stable(prdata)
    ) else $error("read data moved outside a setup");

    // A read clears only what it returned; a flag raised meanwhile must survive
    a_read_clears_status: assert property (
        rd_status_fire |=> ((status_q & $past(clr_snap_q) & ~$past(event_bits)) == '0)
    ) else $error("status read left a returned flag set");

    a_event_beats_clear: assert property (
        rd_status_fire |=> ((status_q & $past(event_bits)) == $past(event_bits))
    ) else $error("event lost to a status read");

    // ----------------------------------------
    // Covers
    // ----------------------------------------
    c_set_write: cover property (wr_set_fire ##1 enable_q != '0);
    c_disable_write: cover property (wr_clr_fire ##1 enable_q == '0);
    c_irq_rise: cover property ($rose(irq));
    c_status_read: cover property (rd_status_fire && clr_snap_q != '0);
    c_event_beats_clear: cover property (rd_status_fire && |(event_bits & clr_snap_q));

endmodule : adc_irq_enable

/* File: adc_irq_pkg.sv */
package adc_irq_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned OFS_W = 12;
    localparam int unsigned CHAN_COUNT = 8;
    localparam int unsigned CONV_EVENT_COUNT = 6;
    localparam int unsigned EVENT_COUNT = CONV_EVENT_COUNT + 2 * CHAN_COUNT;
    localparam int unsigned STRB_W = DATA_W / 8;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [OFS_W-1:0] OFS_ENABLE_SET = 12'h304;
    localparam logic [OFS_W-1:0] OFS_DISABLE = 12'h308;
    localparam logic [OFS_W-1:0] OFS_EVENT_STATUS = 12'h30C;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int unsigned CONV_FIELD_LSB = 0;
    localparam int unsigned LIMIT_FIELD_LSB = CONV_EVENT_COUNT;
    localparam logic [EVENT_COUNT-1:0] ENABLE_RESET = 22'h000000;
    localparam logic [EVENT_COUNT-1:0] STATUS_RESET = 22'h000000;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    // Upper limit sits on the lower bit of each channel pair
    typedef struct packed {
        logic below_lower;
        logic above_upper;
    } limit_pair_t;

    typedef struct packed {
        limit_pair_t [CHAN_COUNT-1:0] chan;
        logic stopped_event;
        logic calibration_finished_event;
        logic result_written_event;
        logic done_event;
        logic end_event;
        logic started_event;
    } adc_event_t;

    typedef enum logic [1:0] {
        BUS_WAIT = 2'b01,
        BUS_REPLY = 2'b10
    } bus_state_t;

endpackage : adc_irq_pkg
